// >>> core/i2c_slave_pkg.sv
// ----------------------------------------------------------------
// Shared constants for the serial port slave
// ----------------------------------------------------------------
package i2c_slave_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;

  // Control register fields
  localparam int unsigned CTRL_STRETCH = 0;
  localparam int unsigned CTRL_RELEASE = 4;
  localparam int unsigned CTRL_OVF = 6;
  localparam int unsigned CTRL_OWN_LSB = 8;
  localparam int unsigned OWN_W = 7;

  // Status register fields
  localparam int unsigned STAT_FULL = 0;
  localparam int unsigned STAT_DIR = 2;
  localparam int unsigned STAT_EVENT = 3;
  localparam int unsigned STAT_ADDR = 5;
  localparam int unsigned STAT_NACK = 6;

  // Reset values
  localparam logic RELEASE_RST = 1'b1;
  localparam logic STRETCH_RST = 1'b0;
  localparam logic [6:0] OWN_ADDR_RST = 7'h00;

  // Synchroniser depth and bit slot counts
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [3:0] ACK_PREP = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // Byte event word carried from the link to the bus side
  localparam int unsigned EV_RX = 8;
  localparam int unsigned EV_ADDR = 9;
  localparam int unsigned EV_DIR = 10;
  localparam int unsigned EV_NACK = 11;
  localparam int unsigned EV_HOLD = 12;
  localparam int unsigned EV_W = 13;

  // Link engine states
  typedef enum logic [1:0] {LS_IDLE, LS_ADDR, LS_RX, LS_TX} link_state_t;

endpackage

// >>> core/bit_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Flip-flop chain synchroniser, one chain per bit
// ----------------------------------------------------------------
module bit_sync
#(
  parameter int unsigned W = 1,
  parameter int unsigned STAGES = 2
)
(
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage_r [STAGES];

  // Fewer than two stages leaves metastability unresolved
  if (STAGES < 2)
  begin : g_bad_stages
    $error("bit_sync needs at least two stages");
  end

  // Plain shift chain; first stage feeds only the second
  always_ff @(posedge clk)
  begin
    stage_r[0] <= d;
    for (int i = 1; i < STAGES; i++)
    begin
      stage_r[i] <= stage_r[i-1];
    end
  end

  assign q = stage_r[STAGES-1];

endmodule
`default_nettype wire

// >>> core/i2c_slave_rx_tx.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Write-address match clears direction, buffers, acknowledges
// - No acknowledge while buffer full or overflowed
// - Event flag set per byte, software clears
// - Stretch enabled: hold clock after each byte
// - Read-address match sets direction, acks, holds clock
// - Buffer write loads shifter; release bit resumes
// - Transmit bits change on falling clock edges
// - Master acknowledge sampled on ninth rising edge
// - Master no-acknowledge ends transfer, await start
// - Transmit event raised on ninth falling edge
// - Release bit low forces clock low safely
module i2c_slave_rx_tx
#(
  parameter int unsigned SYNC_STAGES = i2c_slave_pkg::SYNC_STAGES
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [i2c_slave_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [i2c_slave_pkg::DATA_W-1:0] writedata,
  output logic [i2c_slave_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic link_clk,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import i2c_slave_pkg::*;

  if (SYNC_STAGES < 2)
  begin : g_bad_sync
    $error("SYNC_STAGES must be at least two");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic ckp_r, stretch_r, ov_r, bf_r, event_r, dir_r, addr_r, nack_r;
  logic [6:0] own_r;
  logic [7:0] buf_r;
  logic rel_tgl_r, tx_tgl_r;
  logic ev_s, ev_d_r, ev_pulse;
  logic wr_take, rd_take, ctrl_wr, stat_wr, data_wr, stat_clr;
  logic [DATA_W-1:0] rd_nxt;
  logic [7:0] ev_byte;
  logic ev_dir;
  logic lrst;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3_r;
  logic scl_f, sda_f, scl_d, sda_d;
  logic [12:0] cfg_s;
  logic rel_s, tx_s, ckp_s, stretch_s, ovf_s;
  logic [6:0] own_s;
  logic rel_d_r, tx_d_r, rel_pulse, tx_pulse;
  link_state_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_byte;
  logic ack_r, hold_r, ev_tgl_r, skip_r;
  logic [EV_W-1:0] ev_word_r, ev_nxt;
  logic scl_rise, scl_fall, bus_start, bus_stop, byte_end;
  logic end_hold, addr_match;

  // ----------------------------------------------------------------
  // Avalon-MM slave, bus clock domain
  // ----------------------------------------------------------------

  // Each access waits one cycle, then is taken on the low waitrequest
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      waitrequest <= 1'b1;
    else
      waitrequest <= !((read || write) && waitrequest);
  end

  assign wr_take = write && !waitrequest;
  assign rd_take = read && !waitrequest;
  assign ctrl_wr = wr_take && (address == OFS_CTRL) && byteenable[0];
  assign stat_wr = wr_take && (address == OFS_STAT) && byteenable[0];
  assign data_wr = wr_take && (address == OFS_DATA) && byteenable[0];
  assign stat_clr = stat_wr && writedata[STAT_EVENT];

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    rd_nxt = '0;
    unique case (address)
      OFS_CTRL:
      begin
        rd_nxt[CTRL_STRETCH] = stretch_r;
        rd_nxt[CTRL_RELEASE] = ckp_r;
        rd_nxt[CTRL_OVF] = ov_r;
        rd_nxt[CTRL_OWN_LSB +: OWN_W] = own_r;
      end
      OFS_STAT:
      begin
        rd_nxt[STAT_FULL] = bf_r;
        rd_nxt[STAT_DIR] = dir_r;
        rd_nxt[STAT_EVENT] = event_r;
        rd_nxt[STAT_ADDR] = addr_r;
        rd_nxt[STAT_NACK] = nack_r;
      end
      OFS_DATA: rd_nxt[7:0] = buf_r;
      default: rd_nxt = '0;
    endcase
  end

  // Read data is captured while waitrequest is still high
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      readdata <= '0;
    else if (read && waitrequest)
      readdata <= rd_nxt;
  end

  // ----------------------------------------------------------------
  // Byte events arriving from the link
  // ----------------------------------------------------------------
  bit_sync #(.W(1), .STAGES(SYNC_STAGES)) u_ev_sync
  (
    .clk(clk),
    .d(ev_tgl_r),
    .q(ev_s)
  );

  // The event word is stable long before its toggle is seen here
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ev_d_r <= 1'b0;
    else
      ev_d_r <= ev_s;
  end

  assign ev_pulse = ev_s ^ ev_d_r;
  assign ev_byte = ev_word_r[7:0];
  assign ev_dir = ev_word_r[EV_DIR];

  // Control fields; a stretching byte drops the release bit
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ckp_r <= RELEASE_RST;
      stretch_r <= STRETCH_RST;
      own_r <= OWN_ADDR_RST;
      rel_tgl_r <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        ckp_r <= writedata[CTRL_RELEASE];
        stretch_r <= writedata[CTRL_STRETCH];
      end
      else if (ev_pulse && ev_word_r[EV_HOLD])
        ckp_r <= 1'b0;
      if (ctrl_wr && writedata[CTRL_RELEASE])
        rel_tgl_r <= !rel_tgl_r;
      if (wr_take && (address == OFS_CTRL) && byteenable[1])
        own_r <= writedata[CTRL_OWN_LSB +: OWN_W];
    end
  end

  // Buffer: acknowledged bytes load it; a refused byte is never stored
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      buf_r <= '0;
      bf_r <= 1'b0;
      ov_r <= 1'b0;
      tx_tgl_r <= 1'b0;
    end
    else
    begin
      if (ev_pulse && ev_word_r[EV_RX] && !ev_word_r[EV_NACK] && !bf_r)
      begin
        buf_r <= ev_byte;
        bf_r <= 1'b1;
      end
      else
      begin
        if (data_wr)
          buf_r <= writedata[7:0];
        if (rd_take && (address == OFS_DATA))
          bf_r <= 1'b0;
      end
      if (data_wr)
        tx_tgl_r <= !tx_tgl_r;
      // Overflow set beats a software clear in the same cycle
      if (ev_pulse && ev_word_r[EV_RX] && (bf_r || ev_word_r[EV_NACK]))
        ov_r <= 1'b1;
      else if (ctrl_wr && !writedata[CTRL_OVF])
        ov_r <= 1'b0;
    end
  end

  // Sticky event flag and per-byte status
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      event_r <= 1'b0;
      dir_r <= 1'b0;
      addr_r <= 1'b0;
      nack_r <= 1'b0;
    end
    else
    begin
      if (ev_pulse)
        event_r <= 1'b1;
      else if (stat_clr)
        event_r <= 1'b0;
      if (ev_pulse)
      begin
        addr_r <= ev_word_r[EV_ADDR];
        nack_r <= ev_word_r[EV_NACK];
        if (ev_word_r[EV_ADDR])
          dir_r <= ev_dir;
      end
    end
  end

  // ----------------------------------------------------------------
  // Crossings into the link domain
  // ----------------------------------------------------------------

  // Reset and settings are levels; address and stretch are meant to
  // change only while the bus is idle, as the bits cross one by one
  bit_sync #(.W(1), .STAGES(SYNC_STAGES)) u_rst_sync
  (
    .clk(link_clk),
    .d(sys_rst),
    .q(lrst)
  );

  bit_sync #(.W(13), .STAGES(SYNC_STAGES)) u_cfg_sync
  (
    .clk(link_clk),
    .d({rel_tgl_r, tx_tgl_r, ckp_r, stretch_r, bf_r, ov_r, own_r}),
    .q(cfg_s)
  );

  assign {rel_s, tx_s, ckp_s, stretch_s} = cfg_s[12:9];
  assign ovf_s = cfg_s[8] | cfg_s[7];
  assign own_s = cfg_s[6:0];
  assign tx_byte = buf_r;

  // Pins take a third stage; a change counts once stages agree
  bit_sync #(.W(2), .STAGES(2)) u_pin_sync
  (
    .clk(link_clk),
    .d({scl_in, sda_in}),
    .q(pin_s2)
  );

  always_ff @(posedge link_clk)
  begin
    pin_s3_r <= pin_s2;
    if (pin_s2[1] == pin_s3_r[1])
      scl_f <= pin_s3_r[1];
    if (pin_s2[0] == pin_s3_r[0])
      sda_f <= pin_s3_r[0];
    scl_d <= scl_f;
    sda_d <= sda_f;
  end

  // Toggle edges for release and transmit load
  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      rel_d_r <= 1'b0;
      tx_d_r <= 1'b0;
    end
    else
    begin
      rel_d_r <= rel_s;
      tx_d_r <= tx_s;
    end
  end

  assign rel_pulse = rel_s ^ rel_d_r;
  assign tx_pulse = tx_s ^ tx_d_r;

  // ----------------------------------------------------------------
  // Link engine, link clock domain
  // ----------------------------------------------------------------
  assign scl_rise = scl_f && !scl_d;
  assign scl_fall = !scl_f && scl_d;
  assign bus_start = scl_f && scl_d && sda_d && !sda_f;
  assign bus_stop = scl_f && scl_d && !sda_d && sda_f;
  assign addr_match = (sh_r[7:1] == own_s);
  assign byte_end = scl_fall && (cnt_r == ACK_SLOT) && (st_r != LS_IDLE)
    && !((st_r == LS_ADDR) && !sda_oe);

  // Whether the clock is held once the ninth bit ends
  always_comb
  begin
    unique case (st_r)
      LS_IDLE: end_hold = 1'b0;
      LS_ADDR: end_hold = sh_r[0] | stretch_s;
      LS_RX: end_hold = stretch_s;
      LS_TX: end_hold = !ack_r;
    endcase
    ev_nxt = '0;
    ev_nxt[7:0] = sh_r;
    ev_nxt[EV_RX] = (st_r != LS_TX);
    ev_nxt[EV_ADDR] = (st_r == LS_ADDR);
    ev_nxt[EV_DIR] = sh_r[0];
    ev_nxt[EV_NACK] = (st_r == LS_TX) ? ack_r : !sda_oe;
    ev_nxt[EV_HOLD] = end_hold;
  end

  // Bit engine: sample on rising edges, drive on falling edges
  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      st_r <= LS_IDLE;
      cnt_r <= '0;
      sh_r <= '0;
      ack_r <= 1'b1;
      sda_oe <= 1'b0;
      skip_r <= 1'b0;
    end
    else if (bus_start)
    begin
      st_r <= LS_ADDR;
      cnt_r <= '0;
      sda_oe <= 1'b0;
      skip_r <= 1'b1;
    end
    else if (bus_stop)
    begin
      st_r <= LS_IDLE;
      sda_oe <= 1'b0;
    end
    else
    begin
      // First transmit bit goes out while the clock is held low
      if (tx_pulse && (st_r == LS_TX) && hold_r && (cnt_r == '0))
      begin
        sh_r <= tx_byte;
        sda_oe <= !tx_byte[7];
      end
      if (scl_rise && (st_r != LS_IDLE))
      begin
        if (cnt_r < ACK_SLOT)
        begin
          if (st_r != LS_TX)
            sh_r <= {sh_r[6:0], sda_f};
        end
        else if (st_r == LS_TX)
          ack_r <= sda_f;
      end
      // The fall that closes a start is not a bit slot
      if (scl_fall)
        skip_r <= 1'b0;
      if (scl_fall && (st_r != LS_IDLE) && !skip_r)
      begin
        if (cnt_r == ACK_PREP)
        begin
          cnt_r <= ACK_SLOT;
          unique case (st_r)
            LS_ADDR:
            begin
              sda_oe <= addr_match && !ovf_s;
              if (!addr_match)
                st_r <= LS_IDLE;
            end
            LS_RX: sda_oe <= !ovf_s;
            LS_TX: sda_oe <= 1'b0;
            LS_IDLE: sda_oe <= 1'b0;
          endcase
        end
        else if (cnt_r == ACK_SLOT)
        begin
          cnt_r <= '0;
          sda_oe <= 1'b0;
          if (st_r == LS_ADDR)
            st_r <= !sda_oe ? LS_IDLE : (sh_r[0] ? LS_TX : LS_RX);
          else if ((st_r == LS_TX) && ack_r)
            st_r <= LS_IDLE;
        end
        else
        begin
          cnt_r <= cnt_r + 4'h1;
          if (st_r == LS_TX)
          begin
            sh_r <= {sh_r[6:0], 1'b0};
            sda_oe <= !sh_r[6];
          end
        end
      end
    end
  end

  // Byte event word and its toggle towards the bus side
  always_ff @(posedge link_clk)
  begin
    if (lrst)
    begin
      ev_tgl_r <= 1'b0;
      ev_word_r <= '0;
    end
    else if (byte_end)
    begin
      ev_tgl_r <= !ev_tgl_r;
      ev_word_r <= ev_nxt;
    end
  end

  // Stretch hold: set at the ninth falling edge, cleared by release
  always_ff @(posedge link_clk)
  begin
    if (lrst || bus_start || bus_stop)
      hold_r <= 1'b0;
    else if (byte_end)
      hold_r <= end_hold;
    else if (rel_pulse)
      hold_r <= 1'b0;
  end

  // Clock pull-down starts only once the clock is already seen low
  always_ff @(posedge link_clk)
  begin
    if (lrst)
      scl_oe <= 1'b0;
    else
      scl_oe <= (hold_r || !ckp_s) && (scl_oe || !scl_f);
    scl_out <= 1'b0;
    sda_out <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence addr_seen_s;
    scl_fall && (st_r == LS_ADDR) && (cnt_r == ACK_PREP);
  endsequence

  sequence tx_ninth_s;
    scl_fall && (st_r == LS_TX) && (cnt_r == ACK_SLOT);
  endsequence

  AST_ADDR_ACK: assert property (@(posedge link_clk) disable iff (lrst)
    addr_seen_s and (addr_match && !ovf_s) |=> sda_oe)
    else $error("matching address not acknowledged");
  AST_OVF_NACK: assert property (@(posedge link_clk) disable iff (lrst)
    (scl_fall && (st_r == LS_RX) && (cnt_r == ACK_PREP) && ovf_s)
    |=> !sda_oe ##1 !sda_oe)
    else $error("acknowledge given during overflow");
  AST_TX_HOLD: assert property (@(posedge link_clk) disable iff (lrst)
    (byte_end && (st_r == LS_ADDR) && sh_r[0]) |=> hold_r && (st_r == LS_TX))
    else $error("read address did not hold clock");
  AST_RX_STRETCH: assert property (@(posedge link_clk) disable iff (lrst)
    (byte_end && (st_r == LS_RX) && stretch_s) |=> hold_r)
    else $error("stretch enabled but clock not held");
  AST_SDA_STABLE: assert property (@(posedge link_clk) disable iff (lrst)
    ((st_r == LS_TX) && scl_f && scl_d && !bus_stop) |-> $stable(sda_oe))
    else $error("data changed while clock high");
  AST_ACK_SAMPLE: assert property (@(posedge link_clk) disable iff (lrst)
    (scl_rise && (st_r == LS_TX) && (cnt_r == ACK_SLOT))
    |=> ack_r == $past(sda_f))
    else $error("master acknowledge not sampled");
  AST_NACK_IDLE: assert property (@(posedge link_clk) disable iff (lrst)
    tx_ninth_s and ack_r |=> (st_r == LS_IDLE) && !hold_r)
    else $error("no-acknowledge did not end transfer");
  AST_TX_EVENT: assert property (@(posedge link_clk) disable iff (lrst)
    tx_ninth_s |=> ev_tgl_r != $past(ev_tgl_r))
    else $error("transmit event missing at ninth fall");
  AST_SCL_GATE: assert property (@(posedge link_clk) disable iff (lrst)
    $rose(scl_oe) |-> !$past(scl_f))
    else $error("clock pulled low while seen high");
  AST_TX_COPY: assert property (@(posedge link_clk) disable iff (lrst)
    (tx_pulse && (st_r == LS_TX) && hold_r && (cnt_r == '0) && !scl_fall)
    |=> sh_r == $past(tx_byte))
    else $error("buffer not copied to shifter");
  AST_EVENT_STICKY: assert property (@(posedge clk) disable iff (sys_rst)
    (event_r && !stat_clr) |=> event_r)
    else $error("event flag dropped without software");
  AST_ADDR_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    (ev_pulse && ev_word_r[EV_ADDR] && !bf_r)
    |=> bf_r && (buf_r == $past(ev_byte)) && (dir_r == $past(ev_dir)))
    else $error("address byte not recorded");
  AST_BUS_ANSWER: assert property (@(posedge clk) disable iff (sys_rst)
    ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("bus access not answered in one cycle");

endmodule
`default_nettype wire

// >>> tb/i2c_master_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// Behavioural bus master on the two-wire link
// ----------------------------------------------------------------
module i2c_master_model
#(
  parameter int Q = 8
)
(
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_m,
  output logic sda_m,
  output logic stuck
);
  // Both lines released at power-up; pull-ups take them high
  initial
  begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    stuck = 1'b0;
  end
  // Quarter bit time, counted on the link clock
  task automatic q();
    repeat (Q) @(posedge link_clk);
  endtask
  // Clock released, then a bounded wait while the slave stretches it
  task automatic rise();
    int k;
    scl_m <= 1'b1;
    for (k = 0; k < 4000 && scl !== 1'b1; k++) @(posedge link_clk);
    if (scl !== 1'b1) stuck = 1'b1;
  endtask
  // One bit slot: data set while low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    q();
    sda_m <= b;
    q();
    rise();
    q();
    r = sda;
    q();
    scl_m <= 1'b0;
  endtask
  // Start: data falls while the clock is high
  task automatic start();
    sda_m <= 1'b1;
    q();
    rise();
    q();
    sda_m <= 1'b0;
    q();
    scl_m <= 1'b0;
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    q();
    sda_m <= 1'b0;
    q();
    rise();
    q();
    sda_m <= 1'b1;
    q();
  endtask
  // Most significant bit first, ninth slot is the acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(mack, r);
  endtask
endmodule
`default_nettype wire

// >>> tb/i2c_slave_rx_tx_bench.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_rx_tx_bench;
  import i2c_slave_pkg::*;
  localparam logic [31:0] FULL = 32'h1 << STAT_FULL;
  localparam logic [31:0] DIR = 32'h1 << STAT_DIR;
  localparam logic [31:0] EV = 32'h1 << STAT_EVENT;
  localparam logic [31:0] ADR = 32'h1 << STAT_ADDR;
  logic clk, link_clk, sys_rst, read, write, waitrequest;
  logic [ADDR_W-1:0] address;
  logic [3:0] byteenable;
  logic [DATA_W-1:0] writedata, readdata, rd;
  logic scl_out, scl_oe, sda_out, sda_oe, scl_m, sda_m, stuck;
  logic a0, a1, a2, armed;
  logic [6:0] own;
  logic [7:0] b0, b1, r0, r1;
  logic [7:0] rx_q[$];
  int err_total, n_tests;
  wire scl_w, sda_w;
  // Open-drain wires; an unknown enable counts as released
  assign scl_w = scl_m & ((scl_oe === 1'b1) ? scl_out : 1'b1);
  assign sda_w = sda_m & ((sda_oe === 1'b1) ? sda_out : 1'b1);
  always #20 clk = ~clk;
  // Link clock with its own phase, period 125 ns
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever
    begin
      #62 link_clk = 1'b1;
      #63 link_clk = 1'b0;
    end
  end
  i2c_slave_rx_tx dut (.clk(clk), .sys_rst(sys_rst), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .link_clk(link_clk), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe));
  i2c_master_model m (.link_clk(link_clk), .scl(scl_w), .sda(sda_w),
    .scl_m(scl_m), .sda_m(sda_m), .stuck(stuck));
  // ----------------------------------------------------------------
  // Checking and bus helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic hang();
    err_total++;
    stop_test();
  endtask
  // Request held until waitrequest is seen low, then released
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    int k;
    @(posedge clk);
    address <= a;
    writedata <= wd;
    byteenable <= 4'h3;
    write <= wr;
    read <= !wr;
    for (k = 0; k < 40; k++)
    begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (k == 40) hang();
  endtask
  // Bounded poll of one register bit; the flag crosses clock domains
  task automatic poll(input logic [ADDR_W-1:0] a, input int b);
    int k;
    for (k = 0; k < 1000; k++)
    begin
      bus(1'b0, a, '0, rd);
      if (rd[b] === 1'b1) break;
    end
    if (k == 1000) hang();
  endtask
  task automatic ctl(input logic st);
    bus(1'b1, OFS_CTRL, {17'h0, own, 7'h08, st}, rd);
  endtask
  // Data may only move while the clock is low, once the link left reset
  always @(sda_oe)
    if (armed) check(scl_w, 1'b0);
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    byteenable = 4'h0;
    writedata = '0;
    err_total = 0;
    n_tests = 0;
    armed = 1'b0;
    void'($urandom(32'h855CF064));
    own = 7'($urandom_range(8, 119));
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    // Link side leaves reset a few of its own clocks later
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge link_clk);
    armed = 1'b1;
    bus(1'b0, OFS_CTRL, '0, rd);
    check(rd, 32'h10);
    bus(1'b0, OFS_STAT, '0, rd);
    check(rd, 32'h0);
    bus(1'b1, 4'hC, 32'hFFFF, rd);
    bus(1'b0, 4'hC, '0, rd);
    check(rd, 32'h0);
    ctl(1'b0);
    m.start();
    m.wr_byte({own ^ 7'h01, 1'b0}, a0);
    m.stop();
    check(a0, 1'b1);
    bus(1'b0, OFS_STAT, '0, rd);
    check(rd, 32'h0);
    $display("test reset and address mismatch done");
    // Write transfer, then full buffer and overflow refuse bytes
    m.start();
    m.wr_byte({own, 1'b0}, a0);
    check(a0, 1'b0);
    poll(OFS_STAT, STAT_EVENT);
    check(rd, FULL | EV | ADR);
    bus(1'b0, OFS_DATA, '0, rd);
    check(rd, {24'h0, own, 1'b0});
    bus(1'b1, OFS_STAT, EV, rd);
    bus(1'b0, OFS_STAT, '0, rd);
    check(rd, ADR);
    m.wr_byte(b0, a0);
    rx_q.push_back(b0);
    check(a0, 1'b0);
    poll(OFS_STAT, STAT_EVENT);
    check(rd, FULL | EV);
    bus(1'b1, OFS_STAT, EV, rd);
    m.wr_byte(b1, a1);
    check(a1, 1'b1);
    poll(OFS_CTRL, CTRL_OVF);
    check(rd, {17'h0, own, 8'h50});
    bus(1'b0, OFS_DATA, '0, rd);
    check(rd, rx_q.pop_front());
    m.wr_byte(b1, a2);
    check(a2, 1'b1);
    m.stop();
    ctl(1'b0);
    bus(1'b1, OFS_STAT, EV, rd);
    bus(1'b0, OFS_CTRL, '0, rd);
    check(rd, {17'h0, own, 8'h10});
    $display("test receive and overflow done");
    // Stretch enabled: clock held after every byte until released
    ctl(1'b1);
    rx_q.push_back({own, 1'b0});
    rx_q.push_back(b1);
    fork
      begin
        m.start();
        m.wr_byte({own, 1'b0}, a0);
        m.wr_byte(b1, a1);
        m.stop();
      end
      repeat (2)
      begin
        poll(OFS_STAT, STAT_EVENT);
        check(scl_oe, 1'b1);
        check(scl_w, 1'b0);
        bus(1'b0, OFS_DATA, '0, rd);
        check(rd, rx_q.pop_front());
        bus(1'b1, OFS_STAT, EV, rd);
        ctl(1'b1);
      end
    join
    check({a0, a1}, 2'b00);
    ctl(1'b0);
    $display("test clock stretch done");
    // Read transfer: two bytes out, master refuses the second
    fork
      begin
        m.start();
        m.wr_byte({own, 1'b1}, a0);
        m.rd_byte(1'b0, r0);
        m.rd_byte(1'b1, r1);
        m.stop();
      end
      begin
        poll(OFS_STAT, STAT_EVENT);
        check(rd, FULL | DIR | EV | ADR);
        check(scl_oe, 1'b1);
        bus(1'b0, OFS_DATA, '0, rd);
        check(rd, {24'h0, own, 1'b1});
        bus(1'b1, OFS_STAT, EV, rd);
        bus(1'b1, OFS_DATA, {24'h0, b0}, rd);
        ctl(1'b0);
        poll(OFS_STAT, STAT_EVENT);
        check(rd[STAT_NACK], 1'b0);
        check(scl_oe, 1'b1);
        bus(1'b1, OFS_STAT, EV, rd);
        bus(1'b1, OFS_DATA, {24'h0, b1}, rd);
        ctl(1'b0);
      end
    join
    check(a0, 1'b0);
    check(r0, b0);
    check(r1, b1);
    poll(OFS_STAT, STAT_EVENT);
    check(rd[STAT_NACK], 1'b1);
    check({scl_oe, sda_oe}, 2'b00);
    bus(1'b1, OFS_STAT, EV, rd);
    // After the refusal only a new start is answered
    m.start();
    m.wr_byte({own, 1'b0}, a0);
    m.stop();
    check(a0, 1'b0);
    check(stuck, 1'b0);
    check({scl_out, sda_out}, 2'b00);
    $display("test transmit done");
    stop_test();
  end
endmodule
`default_nettype wire
